// *** rtl/token_node_regs_pkg.sv ***
/*
  Constants for the host register bank of the token-passing node controller:
  register indices, sub-address codes, bit positions, masks, reset values
  and reconfiguration timer figures.
  Assumes the bank is reached over a 32-bit AHB-Lite bus, one word per register.
*/
package token_node_regs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_DIAG = 3'h1;
  localparam logic [2:0] IDX_PTR_HIGH = 3'h2;
  localparam logic [2:0] IDX_PTR_LOW = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [2:0] IDX_SUB_SELECT = 3'h5;
  localparam logic [2:0] IDX_CONFIG = 3'h6;
  localparam logic [2:0] IDX_SHARED = 3'h7;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 4;
  localparam int MAP_TOP_LSB = 5;

  // Sub-address codes at the shared index
  localparam logic [2:0] SUB_TENT_ID = 3'h0;
  localparam logic [2:0] SUB_NODE_ID = 3'h1;
  localparam logic [2:0] SUB_RATE_CFG = 3'h2;
  localparam logic [2:0] SUB_NEXT_NODE = 3'h3;
  localparam logic [2:0] SUB_CLK_CFG = 3'h4;

  // Status bits
  localparam int ST_RI = 7;
  localparam int ST_POR = 4;
  localparam int ST_TEST = 3;
  localparam int ST_RECON = 2;
  localparam int ST_TMA = 1;
  localparam int ST_TA = 0;
  localparam logic [7:0] STATUS_STORED_MASK = 8'h97;
  localparam logic [7:0] STATUS_RESET = 8'h91;

  // Diagnostic bits
  localparam int DG_EXC_REFUSAL = 3;
  localparam int DG_NEW_NEXT = 1;
  localparam logic [7:0] DIAG_EVENT_MASK = 8'hfe;
  localparam logic [7:0] DIAG_READ_KEEP = 8'h0a;
  localparam logic [7:0] DIAG_RESET = 8'h00;

  // Configuration bits
  localparam int CF_RESET = 7;
  localparam int CF_CHAIN = 6;
  localparam int CF_TX_ENABLE = 5;
  localparam int CF_ET1 = 4;
  localparam int CF_ET2 = 3;
  localparam int CF_BACKPLANE = 2;
  localparam logic [7:0] CONFIG_RESET = 8'h18;

  // Sub-address register: bits 7 and 3 are plain storage, 6..4 read zero
  localparam logic [7:0] SUB_SELECT_MASK = 8'h8f;
  localparam int SEL_TOP = 2;

  // Pointer high: bits 5..3 read zero
  localparam logic [7:0] PTR_HIGH_MASK = 8'hc7;
  localparam int PH_READ_MODE = 7;
  localparam int PH_AUTO_INC = 6;

  // Setup 1 bits
  localparam int S1_LINE_DRIVER = 7;
  localparam int S1_FOUR_REFUSALS = 6;
  localparam int S1_RECEIVE_ALL = 4;
  localparam int S1_PRESCALE_MSB = 3;
  localparam int S1_PRESCALE_LSB = 1;
  localparam int S1_SLOW_ARB = 0;
  localparam logic [7:0] RATE_CFG_MASK = 8'hdf;
  localparam logic [7:0] RATE_CFG_RESET = 8'h00;

  // Setup 2 bits
  localparam int S2_FAST_READ = 7;
  localparam int S2_CLOCK_MUL_HIGH = 5;
  localparam int S2_CLOCK_MUL_LOW = 4;
  localparam int S2_ENHANCED = 3;
  localparam int S2_SKIP_IDLE = 2;
  localparam int S2_RECON_HIGH = 1;
  localparam int S2_RECON_LOW = 0;
  localparam logic [7:0] CLK_CFG_MASK = 8'hbf;
  localparam logic [7:0] CLK_CFG_RESET = 8'h00;

  // Reconfiguration timeouts at 5 Mbit/s, counted in bit times
  localparam int unsigned BIT_TIME_NS_5M = 200;
  localparam int unsigned RECON_TIME_NS_00 = 420_000_000;
  localparam int unsigned RECON_TIME_NS_01 = 105_000_000;
  localparam int unsigned RECON_TIME_NS_10 = 52_500_000;
  localparam int unsigned RECON_TIME_NS_11 = 26_250_000;
  localparam int RECON_CNT_W = 22;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// *** rtl/token_node_host_register_bank.sv ***
/*
  Host register bank of a token-passing network node: AHB-Lite slave with
  next-node, status, diagnostic, command, RAM pointer, configuration,
  sub-address and two setup registers, plus the reconfiguration timer.
  Assumes the protocol core runs on mclk and hands over one-cycle event
  pulses and levels; reads take one wait state, writes none.
*/
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module token_node_host_register_bank
  import token_node_regs_pkg::*;
#(
  parameter logic [RECON_CNT_W-1:0] RECON_TICKS_00 = RECON_CNT_W'(RECON_TIME_NS_00 / BIT_TIME_NS_5M),
  parameter logic [RECON_CNT_W-1:0] RECON_TICKS_01 = RECON_CNT_W'(RECON_TIME_NS_01 / BIT_TIME_NS_5M),
  parameter logic [RECON_CNT_W-1:0] RECON_TICKS_10 = RECON_CNT_W'(RECON_TIME_NS_10 / BIT_TIME_NS_5M),
  parameter logic [RECON_CNT_W-1:0] RECON_TICKS_11 = RECON_CNT_W'(RECON_TIME_NS_11 / BIT_TIME_NS_5M)
)
(
  input wire logic mclk, // System clock, 250 MHz
  input wire logic srst, // Hardware reset, synchronous, active high
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word expected
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic nextNodeUpdate, // Core refreshes next node, pulse
  input wire logic [7:0] nextNodeValue, // New next-node identifier
  input wire logic riSet, // Receiver inhibited set, pulse
  input wire logic riClear, // Receiver inhibited clear, pulse
  input wire logic taSet, // Transmitter available set, pulse
  input wire logic taClear, // Transmitter available clear, pulse
  input wire logic tmaSet, // Transmit acknowledged set, pulse
  input wire logic tmaClear, // Transmit acknowledged clear, pulse
  input wire logic reconSet, // Line idle timeout, pulse
  input wire logic testFlag, // Test status level
  input wire logic clearFlags, // Clear-flags command executed, pulse
  input wire logic porClearFlags, // Power-on clear-flags command executed, pulse
  input wire logic [7:0] diagEvent, // Diagnostic set pulses, bits 1,0 ignored
  input wire logic lineIdle, // Receive line idle level
  input wire logic reconRestart, // Restart reconfiguration timer, pulse
  input wire logic rateTick, // One pulse per bit time at current rate
  output logic commandStrobe, // New command written, pulse
  output logic [7:0] commandCode, // Last written command
  output logic [10:0] ramAddress, // Loaded RAM address
  output logic ramAddressLoad, // RAM address loaded, pulse
  output logic readMode, // Pointer read-data mode
  output logic autoIncrement, // Pointer auto-increment
  output logic softReset, // Software reset held, level
  output logic chainEnable, // Command chaining enable
  output logic transmitterEnable, // Transmitter enable
  output logic [1:0] extTimeout, // Extended timeout select
  output logic backplaneMode, // Backplane mode
  output logic [7:0] nodeId, // Node identifier
  output logic [7:0] tentativeId, // Tentative identifier
  output logic lineDriverOutput, // Pulse driver type
  output logic fourRefusals, // Four refusals option
  output logic receiveAll, // Receive-all mode
  output logic [2:0] clockPrescale, // Data rate prescaler
  output logic slowArbitration, // Halved arbitration speed
  output logic fastReadSelect, // Fast host read cycles
  output logic [1:0] clockMultiplier, // Internal clock multiplier select
  output logic enhancedTimingSelect, // New timing when high
  output logic skipIdleWait, // Initialise without idle line
  output logic initWriteEnable, // Initialisation sequence may be written
  output logic newNextNodeFlag, // New next node pending, level
  output logic reconTimeout // Reconfiguration timer expired, pulse
);

  typedef struct packed {
    logic [7:0] nextNode;
    logic [7:0] status;
    logic [7:0] diag;
    logic [7:0] command;
    logic cmdStrobe;
    logic [7:0] ptrHigh;
    logic [7:0] ptrLow;
    logic [10:0] ramAddr;
    logic addrLoad;
    logic [7:0] cfg;
    logic [7:0] subSelect;
    logic [7:0] tentId;
    logic [7:0] nodeIdReg;
    logic [7:0] rateCfg;
    logic [7:0] clkCfg;
    logic [7:0] rdData;
    logic dpValid;
    logic dpWrite;
    logic dpWait;
    logic dpMapped;
    logic [2:0] dpIndex;
    logic [RECON_CNT_W-1:0] reconCount;
    logic reconActive;
    logic reconFire;
  } bank_t;

  localparam bank_t BANK_RESET = '{
    nextNode: 8'h00,
    status: STATUS_RESET,
    diag: DIAG_RESET,
    command: 8'h00,
    cmdStrobe: 1'b0,
    ptrHigh: 8'h00,
    ptrLow: 8'h00,
    ramAddr: 11'h000,
    addrLoad: 1'b0,
    cfg: CONFIG_RESET,
    subSelect: 8'h00,
    tentId: 8'h00,
    nodeIdReg: 8'h00,
    rateCfg: RATE_CFG_RESET,
    clkCfg: CLK_CFG_RESET,
    rdData: 8'h00,
    dpValid: 1'b0,
    dpWrite: 1'b0,
    dpWait: 1'b0,
    dpMapped: 1'b0,
    dpIndex: 3'h0,
    reconCount: '0,
    reconActive: 1'b0,
    reconFire: 1'b0
  };

  bank_t state;
  bank_t next_state;

  // A set arriving with its clear wins, so no event is lost
  function automatic logic [7:0] setClear(input logic [7:0] cur, input logic [7:0] setv,
                                          input logic [7:0] clrv);
    setClear = setv | (cur & ~clrv);
  endfunction

  function automatic logic [7:0] bitAt(input logic b, input int pos);
    bitAt = 8'(b) << pos;
  endfunction

  function automatic logic [RECON_CNT_W-1:0] reconTicks(input logic [1:0] sel);
    case (sel)
      2'h0: reconTicks = RECON_TICKS_00;
      2'h1: reconTicks = RECON_TICKS_01;
      2'h2: reconTicks = RECON_TICKS_10;
      default: reconTicks = RECON_TICKS_11;
    endcase
  endfunction

  logic accept;
  logic readLoad;
  logic writeNow;
  logic [7:0] wByte;
  logic [2:0] sel;
  logic [7:0] readValue;
  logic [7:0] statusSet;
  logic [7:0] statusClr;
  logic [7:0] diagSet;
  logic [7:0] diagClr;

  assign accept = hsel && hready && ((htrans & HTRANS_NONSEQ_BIT) != 2'h0);
  assign readLoad = state.dpValid && !state.dpWrite && state.dpWait;
  assign writeNow = state.dpValid && state.dpWrite && state.dpMapped;
  assign wByte = hwdata[7:0];
  assign sel = state.subSelect[SEL_TOP:0];

  // Register read mux
  always_comb
  begin
    readValue = 8'h00;
    if (!state.dpMapped)
    begin
      readValue = 8'h00;
    end
    else if (state.dpIndex == IDX_STATUS)
    begin
      readValue = (state.status & STATUS_STORED_MASK) | bitAt(testFlag, ST_TEST);
    end
    else if (state.dpIndex == IDX_DIAG)
    begin
      readValue = state.diag & DIAG_EVENT_MASK;
    end
    else if (state.dpIndex == IDX_PTR_HIGH)
    begin
      readValue = state.ptrHigh & PTR_HIGH_MASK;
    end
    else if (state.dpIndex == IDX_PTR_LOW)
    begin
      readValue = state.ptrLow;
    end
    else if (state.dpIndex == IDX_SUB_SELECT)
    begin
      readValue = state.subSelect & SUB_SELECT_MASK;
    end
    else if (state.dpIndex == IDX_CONFIG)
    begin
      readValue = state.cfg;
    end
    else if (state.dpIndex == IDX_SHARED)
    begin
      case (sel)
        SUB_TENT_ID: readValue = state.tentId;
        SUB_NODE_ID: readValue = state.nodeIdReg;
        SUB_RATE_CFG: readValue = state.rateCfg;
        SUB_NEXT_NODE: readValue = state.nextNode;
        SUB_CLK_CFG: readValue = state.clkCfg;
        default: readValue = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    next_state = state;
    next_state.cmdStrobe = 1'b0;
    next_state.addrLoad = 1'b0;
    next_state.reconFire = 1'b0;
    statusSet = 8'h00;
    statusClr = 8'h00;
    diagSet = diagEvent & DIAG_EVENT_MASK & ~bitAt(1'b1, DG_NEW_NEXT);
    diagClr = 8'h00;

    // Bus phases: reads wait one cycle so a preceding write is visible
    if (readLoad)
    begin
      next_state.rdData = readValue;
      next_state.dpWait = 1'b0;
      if (state.dpMapped && state.dpIndex == IDX_DIAG)
      begin
        diagClr = ~DIAG_READ_KEEP;
      end
      if (state.dpMapped && state.dpIndex == IDX_SHARED && sel == SUB_NEXT_NODE)
      begin
        diagClr = diagClr | bitAt(1'b1, DG_NEW_NEXT);
      end
    end
    else
    begin
      next_state.dpValid = accept;
      next_state.dpWrite = hwrite;
      next_state.dpWait = 1'b1;
      next_state.dpIndex = haddr[IDX_MSB:IDX_LSB];
      next_state.dpMapped = (haddr[31:MAP_TOP_LSB] == '0);
    end

    if (writeNow)
    begin
      if (state.dpIndex == IDX_DIAG)
      begin
        next_state.command = wByte;
        next_state.cmdStrobe = 1'b1;
      end
      else if (state.dpIndex == IDX_PTR_HIGH)
      begin
        next_state.ptrHigh = wByte & PTR_HIGH_MASK;
      end
      else if (state.dpIndex == IDX_PTR_LOW)
      begin
        next_state.ptrLow = wByte;
        next_state.ramAddr = {state.ptrHigh[2:0], wByte};
        next_state.addrLoad = 1'b1;
      end
      else if (state.dpIndex == IDX_SUB_SELECT)
      begin
        next_state.subSelect = wByte & SUB_SELECT_MASK;
        next_state.cfg[1:0] = wByte[1:0];
      end
      else if (state.dpIndex == IDX_CONFIG)
      begin
        next_state.cfg = wByte;
        next_state.subSelect[1:0] = wByte[1:0];
        next_state.subSelect[SEL_TOP] = 1'b0;
      end
      else if (state.dpIndex == IDX_SHARED)
      begin
        case (sel)
          SUB_TENT_ID: next_state.tentId = wByte;
          SUB_NODE_ID:
          begin
            next_state.nodeIdReg = wByte;
            statusSet = bitAt(wByte == 8'h00, ST_POR);
          end
          SUB_RATE_CFG: next_state.rateCfg = wByte & RATE_CFG_MASK;
          SUB_CLK_CFG: next_state.clkCfg = wByte & CLK_CFG_MASK;
          default: next_state.tentId = state.tentId;
        endcase
      end
    end

    // Next-node refresh from the core
    if (nextNodeUpdate)
    begin
      next_state.nextNode = nextNodeValue;
      diagSet = diagSet | bitAt(1'b1, DG_NEW_NEXT);
    end

    if (porClearFlags)
    begin
      diagClr = diagClr | bitAt(1'b1, DG_EXC_REFUSAL);
    end
    next_state.diag = setClear(state.diag, diagSet, diagClr) & DIAG_EVENT_MASK;

    statusSet = statusSet | bitAt(riSet, ST_RI) | bitAt(taSet, ST_TA)
      | bitAt(tmaSet, ST_TMA) | bitAt(reconSet, ST_RECON);
    statusClr = bitAt(riClear, ST_RI) | bitAt(taClear, ST_TA) | bitAt(tmaClear, ST_TMA)
      | bitAt(clearFlags, ST_RECON) | bitAt(clearFlags, ST_POR);
    next_state.status = setClear(state.status, statusSet, statusClr) & STATUS_STORED_MASK;

    // Timer length is sampled only at restart, a running timeout keeps its length
    if (reconRestart)
    begin
      next_state.reconCount = reconTicks(state.clkCfg[S2_RECON_HIGH:S2_RECON_LOW]);
      next_state.reconActive = 1'b1;
    end
    else if (state.reconActive && rateTick)
    begin
      if (state.reconCount <= RECON_CNT_W'(1))
      begin
        next_state.reconActive = 1'b0;
        next_state.reconFire = 1'b1;
      end
      else
      begin
        next_state.reconCount = state.reconCount - RECON_CNT_W'(1);
      end
    end

    // Software reset spares configuration and both setup registers
    if (state.cfg[CF_RESET])
    begin
      next_state.nextNode = 8'h00;
      next_state.status = STATUS_RESET;
      next_state.diag = DIAG_RESET;
      next_state.reconActive = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state <= BANK_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign hreadyout = !readLoad;
  assign hresp = HRESP_OKAY;
  assign hrdata = {24'h000000, state.rdData};
  assign commandStrobe = state.cmdStrobe;
  assign commandCode = state.command;
  assign ramAddress = state.ramAddr;
  assign ramAddressLoad = state.addrLoad;
  assign readMode = state.ptrHigh[PH_READ_MODE];
  assign autoIncrement = state.ptrHigh[PH_AUTO_INC];
  assign softReset = state.cfg[CF_RESET];
  assign chainEnable = state.cfg[CF_CHAIN];
  assign transmitterEnable = state.cfg[CF_TX_ENABLE];
  assign extTimeout = {state.cfg[CF_ET1], state.cfg[CF_ET2]};
  assign backplaneMode = state.cfg[CF_BACKPLANE];
  assign nodeId = state.nodeIdReg;
  assign tentativeId = state.tentId;
  assign lineDriverOutput = state.rateCfg[S1_LINE_DRIVER];
  assign fourRefusals = state.rateCfg[S1_FOUR_REFUSALS];
  assign receiveAll = state.rateCfg[S1_RECEIVE_ALL];
  assign clockPrescale = state.rateCfg[S1_PRESCALE_MSB:S1_PRESCALE_LSB];
  assign slowArbitration = state.rateCfg[S1_SLOW_ARB];
  assign fastReadSelect = state.clkCfg[S2_FAST_READ];
  assign clockMultiplier = {state.clkCfg[S2_CLOCK_MUL_HIGH], state.clkCfg[S2_CLOCK_MUL_LOW]};
  assign enhancedTimingSelect = state.clkCfg[S2_ENHANCED];
  assign skipIdleWait = state.clkCfg[S2_SKIP_IDLE];
  assign initWriteEnable = state.clkCfg[S2_SKIP_IDLE] || lineIdle;
  assign newNextNodeFlag = state.diag[DG_NEW_NEXT];
  assign reconTimeout = state.reconFire;

endmodule

`default_nettype wire

// *** testbench/token_node_host_register_bank_properties.sv ***
/*
  Concurrent checks on the host register bank ports.
  Assumes word transfers on one AHB-Lite slave, writes with no wait state.
*/
`timescale 1ns/1ps
`default_nettype none
module token_node_host_register_bank_properties
  import token_node_regs_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic srst, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hresp, // Response
  input wire logic nextNodeUpdate, // Next-node refresh
  input wire logic lineIdle, // Line idle
  input wire logic rateTick, // Bit time tick
  input wire logic commandStrobe, // Command pulse
  input wire logic [7:0] commandCode, // Command
  input wire logic [10:0] ramAddress, // RAM address
  input wire logic ramAddressLoad, // Address load pulse
  input wire logic softReset, // Software reset
  input wire logic transmitterEnable, // Transmitter enable
  input wire logic [1:0] extTimeout, // Timeout select
  input wire logic receiveAll, // Receive all
  input wire logic skipIdleWait, // Skip idle
  input wire logic initWriteEnable, // Init write allowed
  input wire logic newNextNodeFlag, // New next node
  input wire logic reconTimeout // Timer expiry
);
  logic apWr;
  logic [2:0] apIdx;
  logic cmdWr;
  logic lowWr;

  // Address phase is remembered so the data phase can be tied to its effect
  always_ff @(posedge mclk)
  begin
    apWr <= !srst && hsel && hready && htrans[1] && hwrite && haddr[31:5] == 27'h0;
    apIdx <= haddr[4:2];
  end
  assign cmdWr = apWr && apIdx == IDX_DIAG;
  assign lowWr = apWr && apIdx == IDX_PTR_LOW;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  chk_cmd_start: assert property (cmdWr |=> commandStrobe && commandCode == $past(hwdata[7:0]))
    else $error("command write did not start command");
  chk_cmd_cause: assert property (commandStrobe |-> $past(cmdWr))
    else $error("command strobe without write");
  chk_low_loads: assert property (lowWr |=> ramAddressLoad && ramAddress[7:0] == $past(hwdata[7:0]))
    else $error("low pointer write did not load address");
  chk_new_next: assert property (nextNodeUpdate && !softReset |=> newNextNodeFlag)
    else $error("refresh did not set new next flag");
  chk_soft_clear: assert property (softReset |=> !newNextNodeFlag)
    else $error("software reset left diagnostic flag");
  chk_hw_reset: assert property (disable iff (1'b0) $fell(srst) |->
    extTimeout == 2'b11 && !transmitterEnable && !receiveAll)
    else $error("hardware reset values wrong");
  chk_byte_wide: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above byte");
  chk_resp_okay: assert property (!hresp)
    else $error("bad response");
  chk_init_gate: assert property (initWriteEnable == (skipIdleWait || lineIdle))
    else $error("init write gate wrong");
  chk_recon_tick: assert property (reconTimeout |-> $past(rateTick) && !$past(reconTimeout))
    else $error("timeout not after a tick");

  cover property (lowWr);
  cover property (reconTimeout);
  cover property (softReset ##1 !softReset);
endmodule
bind token_node_host_register_bank token_node_host_register_bank_properties chk_u (.*);
`default_nettype wire

// *** testbench/host_bus_model.sv ***
/*
  Host processor on AHB-Lite: single word transfers, one at a time.
  Assumes its tasks are entered just after a rising edge of mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
  input wire logic mclk, // Clock
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output var logic hsel, // Select
  output var logic [31:0] haddr, // Address
  output var logic [1:0] htrans, // Transfer type
  output var logic hwrite, // Write
  output var logic [2:0] hsize, // Size
  output var logic [31:0] hwdata // Write data
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Ready is sampled mid-cycle so the edge update cannot race it
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] r);
    logic ok;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do
    begin
      @(negedge mclk);
      ok = hready;
      @(posedge mclk);
    end while (ok !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    haddr <= ~a;
    hwdata <= {24'h0, d};
    do
    begin
      @(negedge mclk);
      ok = hready;
      r = hrdata;
      @(posedge mclk);
    end while (ok !== 1'b1);
    // Released data lines do not keep the old value
    hwdata <= ~{24'h0, d};
  endtask
endmodule
`default_nettype wire

// *** testbench/token_node_host_register_bank_bench.sv ***
/*
  Self-checking bench for the host register bank, one task per scenario.
  Assumes the host model drives the bus and the bench plays the protocol core.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(v, e) begin checked++; if ((v) !== (e)) begin fails++; \
  $display("ERROR %0t got %h want %h", $time, v, e); end end
`define PK(v, e) begin @(negedge mclk); `CHK(v, e) @(posedge mclk); end
module token_node_host_register_bank_bench;
  import token_node_regs_pkg::*;
  localparam int TK [4] = '{8, 4, 3, 2};
  int fails = 0;
  int checked = 0;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic lineIdle = 1'b0;
  logic [11:0] ev = 12'h0;
  logic [7:0] nextNodeValue = 8'h0;
  logic [7:0] diagEvent = 8'h0;
  logic hsel, hwrite, hreadyout, commandStrobe, ramAddressLoad, readMode, autoIncrement;
  logic transmitterEnable, receiveAll, slowArbitration, lineDriverOutput, fastReadSelect;
  logic enhancedTimingSelect, initWriteEnable, newNextNodeFlag, reconTimeout;
  logic [1:0] htrans, clockMultiplier;
  logic [2:0] hsize, clockPrescale;
  logic [7:0] commandCode;
  logic [10:0] ramAddress;
  logic [31:0] haddr, hwdata, hrdata;

  host_bus_model hm (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // Short timer lengths keep the run brief; expectations use the same table
  token_node_host_register_bank #(.RECON_TICKS_00(22'(TK[0])), .RECON_TICKS_01(22'(TK[1])),
    .RECON_TICKS_10(22'(TK[2])), .RECON_TICKS_11(22'(TK[3]))) dut_u (
    .mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
    .hrdata(hrdata), .nextNodeUpdate(ev[0]), .nextNodeValue(nextNodeValue), .riSet(ev[1]),
    .riClear(ev[2]), .taSet(ev[3]), .taClear(ev[4]), .tmaSet(ev[5]), .tmaClear(ev[6]),
    .reconSet(ev[7]), .testFlag(1'b0), .clearFlags(ev[8]), .porClearFlags(ev[9]),
    .diagEvent(diagEvent), .lineIdle(lineIdle), .reconRestart(ev[10]), .rateTick(ev[11]),
    .commandStrobe(commandStrobe), .commandCode(commandCode), .ramAddress(ramAddress),
    .ramAddressLoad(ramAddressLoad), .readMode(readMode), .autoIncrement(autoIncrement),
    .softReset(), .chainEnable(), .transmitterEnable(transmitterEnable), .extTimeout(),
    .backplaneMode(), .nodeId(), .tentativeId(), .lineDriverOutput(lineDriverOutput),
    .fourRefusals(), .receiveAll(receiveAll), .clockPrescale(clockPrescale),
    .slowArbitration(slowArbitration), .fastReadSelect(fastReadSelect),
    .clockMultiplier(clockMultiplier), .enhancedTimingSelect(enhancedTimingSelect),
    .skipIdleWait(), .initWriteEnable(initWriteEnable), .newNextNodeFlag(newNextNodeFlag),
    .reconTimeout(reconTimeout));

  initial
  begin
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] ad(input logic [2:0] i);
    return {27'h0, i, 2'b00};
  endfunction
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    logic [31:0] r;
    hm.xfer(ad(i), 1'b1, d, r);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] r;
    hm.xfer(a, 1'b0, 8'h00, r);
    `CHK(r, {24'h0, e})
  endtask
  task automatic pulse(input logic [11:0] m, input logic [7:0] d);
    ev <= m;
    diagEvent <= d;
    @(posedge mclk);
    ev <= 12'h0;
    diagEvent <= 8'h0;
  endtask
  task automatic do_reset;
    srst <= 1'b1;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic t_reset;
    logic [31:0] r;
    rdchk(ad(IDX_STATUS), 8'h91);
    rdchk(ad(IDX_DIAG), 8'h00);
    rdchk(ad(IDX_CONFIG), 8'h18);
    hm.xfer(32'h20, 1'b1, 8'hff, r);
    rdchk(32'h20, 8'h00);
    wr(IDX_SUB_SELECT, SUB_RATE_CFG);
    rdchk(ad(IDX_SHARED), 8'h00);
    wr(IDX_SUB_SELECT, SUB_NEXT_NODE);
    rdchk(ad(IDX_SHARED), 8'h00);
    $display("test reset done");
  endtask
  task automatic t_next_diag;
    nextNodeValue <= 8'h5a;
    pulse(12'h001, 8'h00);
    `PK(newNextNodeFlag, 1)
    rdchk(ad(IDX_SHARED), 8'h5a);
    `PK(newNextNodeFlag, 0)
    wr(IDX_SHARED, 8'hff);
    rdchk(ad(IDX_SHARED), 8'h5a);
    pulse(12'h001, 8'hfc);
    rdchk(ad(IDX_DIAG), 8'hfe);
    rdchk(ad(IDX_DIAG), 8'h0a);
    pulse(12'h200, 8'h00);
    rdchk(ad(IDX_DIAG), 8'h02);
    $display("test next node and diagnostics done");
  endtask
  task automatic t_command_pointer;
    wr(IDX_DIAG, 8'h01);
    wr(IDX_DIAG, 8'h0c);
    `PK(commandStrobe, 1)
    `PK(commandCode, 8'h0c)
    wr(IDX_PTR_HIGH, 8'hc5);
    wr(IDX_PTR_LOW, 8'h3c);
    `PK(ramAddressLoad, 1)
    wr(IDX_PTR_HIGH, 8'h02);
    `PK(ramAddress, 11'h53c)
    `PK(readMode, 0)
    wr(IDX_PTR_HIGH, 8'hc5);
    rdchk(ad(IDX_PTR_HIGH), 8'hc5);
    `PK(autoIncrement, 1)
    $display("test command and pointer done");
  endtask
  task automatic t_select;
    wr(IDX_CONFIG, 8'h1b);
    rdchk(ad(IDX_SUB_SELECT), 8'h03);
    wr(IDX_SUB_SELECT, SUB_CLK_CFG);
    wr(IDX_SHARED, 8'hbf);
    rdchk(ad(IDX_SHARED), 8'hbf);
    `PK(fastReadSelect, 1)
    `PK(clockMultiplier, 2'b11)
    `PK(enhancedTimingSelect, 1)
    wr(IDX_SUB_SELECT, 8'h07);
    wr(IDX_CONFIG, 8'h1a);
    rdchk(ad(IDX_SUB_SELECT), 8'h02);
    wr(IDX_SHARED, 8'hdf);
    `PK(lineDriverOutput, 1)
    `PK(clockPrescale, 3'h7)
    `PK(slowArbitration, 1)
    wr(IDX_SUB_SELECT, 8'h01);
    rdchk(ad(IDX_CONFIG), 8'h19);
    $display("test sub-address done");
  endtask
  task automatic t_soft;
    pulse(12'h100, 8'h00);
    rdchk(ad(IDX_STATUS), 8'h81);
    wr(IDX_CONFIG, 8'hb8);
    wr(IDX_CONFIG, 8'h38);
    rdchk(ad(IDX_STATUS), 8'h91);
    rdchk(ad(IDX_DIAG), 8'h00);
    rdchk(ad(IDX_CONFIG), 8'h38);
    `PK(receiveAll, 1)
    wr(IDX_SUB_SELECT, SUB_NEXT_NODE);
    rdchk(ad(IDX_SHARED), 8'h00);
    $display("test software reset done");
  endtask
  task automatic t_timer;
    int n;
    logic done;
    wr(IDX_SUB_SELECT, SUB_CLK_CFG);
    for (int c = 0; c < 4; c++)
    begin
      n = 0;
      done = 1'b0;
      lineIdle <= c[0];
      wr(IDX_SHARED, 8'(c));
      pulse(12'h400, 8'h00);
      // A mid-run change must wait for the next restart
      wr(IDX_SHARED, 8'(3 - c));
      `PK(initWriteEnable, c[0])
      while (!done && n < 20)
      begin
        pulse(12'h800, 8'h00);
        n++;
        @(negedge mclk);
        done = (reconTimeout === 1'b1);
        @(posedge mclk);
      end
      `CHK(n, TK[c])
    end
    do_reset();
    rdchk(ad(IDX_CONFIG), 8'h18);
    `PK(receiveAll, 0)
    $display("test timer and hardware reset done");
  endtask

  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end

  initial
  begin
    do_reset();
    t_reset();
    t_next_diag();
    t_command_pointer();
    t_select();
    t_soft();
    t_timer();
    tally_and_finish();
  end
endmodule
`default_nettype wire
